// file: design/uos_cfg.svh
`ifndef UOS_CFG_SVH
`define UOS_CFG_SVH

// ****************************************
// register map
// ****************************************
`define UOS_ADDR_STATUS 8'h00
`define UOS_ADDR_CTRL 8'h04
`define UOS_ADDR_LINE 8'h08

// ****************************************
// status field positions
// ****************************************
`define UOS_BIT_ID 7
`define UOS_BIT_LSTABLE 5
`define UOS_BIT_SESSION 3
`define UOS_BIT_SESS_END 2
`define UOS_BIT_BUS_VALID 0

// control and line-state register fields
`define UOS_BIT_MON_EN 0
`define UOS_BIT_LINE_SE0 0
`define UOS_BIT_LINE_J 1

// ****************************************
// reset values
// ****************************************
`define UOS_RST_WORD 32'h0000_0000
`define UOS_RST_MON_EN 1'b1

// ****************************************
// timing
// ****************************************
`define UOS_CLK_MHZ 100
`define UOS_STABLE_TIME_US 1000
`define UOS_STABLE_CYCLES (`UOS_STABLE_TIME_US * `UOS_CLK_MHZ)
`define UOS_SYNC_STAGES 2

`endif

// file: design/uos_pkg.sv
package uos_pkg;
  typedef logic [31:0] uos_word_t;
  typedef logic [7:0] uos_addr_t;
  typedef struct packed {
    logic cable_type_pin_state;
    logic session_valid_flag;
    logic b_session_end_flag;
    logic a_bus_power_valid_flag;
    logic single_ended_zero_flag;
    logic idle_line_level_flag;
  } uos_pins_t;
endpackage

// file: design/uos_line_if.sv
`timescale 1ns/1ps
interface uos_line_if;
  logic single_ended_zero_flag;
  logic idle_line_level_flag;
  logic monitor_enable;
  logic line_stable_flag;
  modport monitor_mp (
    input single_ended_zero_flag,
    input idle_line_level_flag,
    input monitor_enable,
    output line_stable_flag
  );
  modport owner_mp (
    output single_ended_zero_flag,
    output idle_line_level_flag,
    output monitor_enable,
    input line_stable_flag
  );
endinterface

// file: design/uos_sync.sv
`timescale 1ns/1ps
`include "uos_cfg.svh"
module uos_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule

// file: design/uos_stable.sv
`timescale 1ns/1ps
`include "uos_cfg.svh"
module uos_stable #(
  parameter int STABLE_CYCLES = `UOS_STABLE_CYCLES,
  parameter int CNT_W = $clog2(STABLE_CYCLES + 1)
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  uos_line_if.monitor_mp line
);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(STABLE_CYCLES);

  logic [1:0] prev_q;
  logic [1:0] prev_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic flag_q;
  logic flag_d;
  logic [1:0] cur;

  assign cur = {line.idle_line_level_flag, line.single_ended_zero_flag};

  always_comb begin
    prev_d = cur;
    cnt_d = cnt_q;
    if (!line.monitor_enable) begin
      cnt_d = '0;
    end else if (cur != prev_q) begin
      // any edge on either flag restarts the window
      cnt_d = '0;
    end else if (cnt_q != CNT_MAX) begin
      cnt_d = cnt_q + CNT_W'(1);
    end
    flag_d = (cnt_d == CNT_MAX);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_q <= 2'b00;
      cnt_q <= '0;
      flag_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      cnt_q <= cnt_d;
      flag_q <= flag_d;
    end
  end

  assign line.line_stable_flag = flag_q;
endmodule

// file: design/uos_top.sv
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "uos_cfg.svh"
module uos_top
  import uos_pkg::*;
#(
  parameter int STABLE_CYCLES = `UOS_STABLE_CYCLES
) (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic ID_PIN_I,
  input wire logic SESSION_VALID_I,
  input wire logic SESSION_END_I,
  input wire logic BUS_VALID_I,
  input wire logic SE0_I,
  input wire logic IDLE_LINE_LEVEL_FLAG_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  output logic LINE_STABLE_O
);
  // ****************************************
  // pin synchronisation
  // ****************************************
  uos_pins_t pins_raw;
  uos_pins_t pins_sync;

  assign pins_raw = '{
    cable_type_pin_state: ID_PIN_I,
    session_valid_flag: SESSION_VALID_I,
    b_session_end_flag: SESSION_END_I,
    a_bus_power_valid_flag: BUS_VALID_I,
    single_ended_zero_flag: SE0_I,
    idle_line_level_flag: IDLE_LINE_LEVEL_FLAG_I
  };

  uos_sync #(
    .WIDTH($bits(uos_pins_t))
  ) u_sync (
    .clk_i(CLOCK_I),
    .nrst_i(NRST_I),
    .async_i(pins_raw),
    .sync_o(pins_sync)
  );

  // ****************************************
  // line stability monitor
  // ****************************************
  uos_line_if line_if ();
  logic mon_en_q;
  logic mon_en_d;

  assign line_if.single_ended_zero_flag = pins_sync.single_ended_zero_flag;
  assign line_if.idle_line_level_flag = pins_sync.idle_line_level_flag;
  assign line_if.monitor_enable = mon_en_q;

  uos_stable #(
    .STABLE_CYCLES(STABLE_CYCLES)
  ) u_stable (
    .clk_i(CLOCK_I),
    .nrst_i(NRST_I),
    .line(line_if.monitor_mp)
  );

  // ****************************************
  // status register
  // ****************************************
  uos_word_t status_q;
  uos_word_t status_d;
  logic [1:0] line_q;
  logic [1:0] line_d;

  always_comb begin
    status_d = `UOS_RST_WORD;
    status_d[`UOS_BIT_ID] = pins_sync.cable_type_pin_state;
    status_d[`UOS_BIT_LSTABLE] = line_if.line_stable_flag;
    status_d[`UOS_BIT_SESSION] = pins_sync.session_valid_flag;
    status_d[`UOS_BIT_SESS_END] = pins_sync.b_session_end_flag;
    status_d[`UOS_BIT_BUS_VALID] = pins_sync.a_bus_power_valid_flag;
    line_d[`UOS_BIT_LINE_SE0] = pins_sync.single_ended_zero_flag;
    line_d[`UOS_BIT_LINE_J] = pins_sync.idle_line_level_flag;
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      status_q <= `UOS_RST_WORD;
      line_q <= 2'b00;
    end else begin
      status_q <= status_d;
      line_q <= line_d;
    end
  end

  // ****************************************
  // register port
  // ****************************************
  uos_word_t rdata_q;
  uos_word_t rdata_d;

  always_comb begin
    mon_en_d = mon_en_q;
    // status is read-only, so writes there are dropped
    if (WR_I && ADDR_I == `UOS_ADDR_CTRL) begin
      mon_en_d = WDATA_I[`UOS_BIT_MON_EN];
    end
  end

  always_comb begin
    // data stand for one cycle only, zero otherwise
    rdata_d = `UOS_RST_WORD;
    if (RD_I) begin
      if (ADDR_I == `UOS_ADDR_STATUS) begin
        rdata_d = status_q;
      end else if (ADDR_I == `UOS_ADDR_CTRL) begin
        rdata_d[`UOS_BIT_MON_EN] = mon_en_q;
      end else if (ADDR_I == `UOS_ADDR_LINE) begin
        rdata_d[1:0] = line_q;
      end else begin
        rdata_d = `UOS_RST_WORD;
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mon_en_q <= `UOS_RST_MON_EN;
      rdata_q <= `UOS_RST_WORD;
    end else begin
      mon_en_q <= mon_en_d;
      rdata_q <= rdata_d;
    end
  end

  assign RDATA_O = rdata_q;
  assign LINE_STABLE_O = status_q[`UOS_BIT_LSTABLE];
endmodule

// file: verif/uos_top_assertions.sv
`timescale 1ns/1ps
module uos_top_checker #(
  parameter int STABLE_CYCLES = 20
) (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic ID_PIN_I,
  input wire logic SESSION_VALID_I,
  input wire logic SESSION_END_I,
  input wire logic BUS_VALID_I,
  input wire logic SE0_I,
  input wire logic IDLE_LINE_LEVEL_FLAG_I,
  input wire logic [7:0] ADDR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic LINE_STABLE_O
);
  logic [2:0] up_q;
  logic [1:0] ln_q;
  int run_q;
  logic rd_st;
  // status reads only count once the sync flops have refilled
  assign rd_st = RD_I && ADDR_I == 8'h00 && up_q == 3'h7;
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      up_q <= 3'h0;
      ln_q <= 2'h0;
      run_q <= 0;
    end else begin
      up_q <= up_q + {2'h0, up_q != 3'h7};
      ln_q <= {SE0_I, IDLE_LINE_LEVEL_FLAG_I};
      run_q <= (ln_q != {SE0_I, IDLE_LINE_LEVEL_FLAG_I}) ? 0 : run_q + int'(run_q < 100000);
    end
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  property p_id;
    $stable(ID_PIN_I)[*5] ##0 rd_st |=> RDATA_O[7] == $past(ID_PIN_I);
  endproperty
  a_id: assert property (p_id) else $error("id bit wrong");
  property p_sess;
    $stable(SESSION_VALID_I)[*5] ##0 rd_st |=> RDATA_O[3] == $past(SESSION_VALID_I);
  endproperty
  a_sess: assert property (p_sess) else $error("session bit wrong");
  property p_send;
    $stable(SESSION_END_I)[*5] ##0 rd_st |=> RDATA_O[2] == $past(SESSION_END_I);
  endproperty
  a_send: assert property (p_send) else $error("end bit wrong");
  property p_bus;
    $stable(BUS_VALID_I)[*5] ##0 rd_st |=> RDATA_O[0] == $past(BUS_VALID_I);
  endproperty
  a_bus: assert property (p_bus) else $error("bus bit wrong");
  property p_unused;
    rd_st |=> (RDATA_O & 32'hFFFF_FF52) == 32'h0000_0000;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits set");
  property p_reset;
    disable iff (1'b0) !NRST_I |-> RDATA_O == 32'h0000_0000 && !LINE_STABLE_O;
  endproperty
  a_reset: assert property (p_reset) else $error("not clear in reset");
  property p_lrise;
    $rose(LINE_STABLE_O) |-> run_q >= STABLE_CYCLES + 1;
  endproperty
  a_lrise: assert property (p_lrise) else $error("stable too early");
  property p_lfall;
    $changed(SE0_I) || $changed(IDLE_LINE_LEVEL_FLAG_I) |-> ##[1:6] !LINE_STABLE_O;
  endproperty
  a_lfall: assert property (p_lfall) else $error("stable kept");
endmodule
bind uos_top uos_top_checker #(.STABLE_CYCLES(STABLE_CYCLES)) uos_top_checker_inst (
  .CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .ID_PIN_I(ID_PIN_I),
  .SESSION_VALID_I(SESSION_VALID_I), .SESSION_END_I(SESSION_END_I),
  .BUS_VALID_I(BUS_VALID_I), .SE0_I(SE0_I), .IDLE_LINE_LEVEL_FLAG_I(IDLE_LINE_LEVEL_FLAG_I), .ADDR_I(ADDR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .LINE_STABLE_O(LINE_STABLE_O)
);

// file: verif/uos_cable_model.sv
`timescale 1ns/1ps
module uos_cable_model (
  input wire logic type_a_i,
  input wire logic vbus_up_i,
  input wire logic a_role_i,
  output logic id_o,
  output logic sess_o,
  output logic end_o,
  output logic bus_o
);
  // a Type-A plug grounds the id pin
  assign id_o = !type_a_i;
  assign sess_o = vbus_up_i;
  assign end_o = !vbus_up_i && !a_role_i;
  assign bus_o = vbus_up_i && a_role_i;
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import uos_pkg::*;
  localparam int SC = 20;
  logic clk, nrst, wr = 1'b0, rd = 1'b0, lst;
  logic type_a = 1'b0, vbus = 1'b0, a_role = 1'b0, se0 = 1'b0, jst = 1'b0;
  logic id, sess, send, bus;
  uos_addr_t addr = 8'h00;
  uos_word_t wdata = 32'h0000_0000, rdata, got;
  int miscompares = 0;
  int comparisons = 0;
  logic [2:0] tbl [4] = '{3'h0, 3'h6, 3'h3, 3'h5};
  uos_cable_model uos_cable_model_inst (.type_a_i(type_a), .vbus_up_i(vbus),
    .a_role_i(a_role), .id_o(id), .sess_o(sess), .end_o(send), .bus_o(bus));
  uos_top #(.STABLE_CYCLES(SC)) uos_top_inst (.CLOCK_I(clk), .NRST_I(nrst),
    .ID_PIN_I(id), .SESSION_VALID_I(sess), .SESSION_END_I(send), .BUS_VALID_I(bus),
    .SE0_I(se0), .IDLE_LINE_LEVEL_FLAG_I(jst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .LINE_STABLE_O(lst));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input uos_word_t seen, input uos_word_t exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd_reg(input uos_addr_t a, output uos_word_t d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic wr_reg(input uos_addr_t a, input uos_word_t d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic summarize();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // nothing here waits on a handshake, so one global limit covers hangs
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
  initial begin
    // a real falling edge at time zero, so the async reset branches run
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(8'h04, got);
    chk(got, 32'h0000_0001);
    for (int k = 0; k < 4; k++) begin
      {type_a, vbus, a_role} <= tbl[k];
      se0 <= k[0];
      jst <= ~k[0];
      repeat (5) @(posedge clk);
      rd_reg(8'h00, got);
      chk(got, {24'h00_0000, ~tbl[k][2], 3'h0, tbl[k][1], ~|tbl[k][1:0], 1'b0, &tbl[k][1:0]});
    end
    $display("pin test done");
    type_a <= 1'b0;
    se0 <= 1'b0;
    rd_reg(8'h00, got);
    chk(got & 32'h0000_0080, 32'h0000_0000);
    repeat (3) @(posedge clk);
    wr_reg(8'h00, 32'hFFFF_FFFF);
    rd_reg(8'h00, got);
    chk(got, 32'h0000_0080);
    rd_reg(8'h40, got);
    chk(got, 32'h0000_0000);
    $display("access test done");
    se0 <= 1'b1;
    repeat (SC - 2) @(posedge clk);
    chk({31'h0000_0000, lst}, 32'h0000_0000);
    repeat (10) @(posedge clk);
    chk({31'h0000_0000, lst}, 32'h0000_0001);
    rd_reg(8'h00, got);
    chk(got & 32'h0000_0020, 32'h0000_0020);
    rd_reg(8'h08, got);
    chk(got, 32'h0000_0001);
    jst <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0000_0000, lst}, 32'h0000_0000);
    $display("line test done");
    wr_reg(8'h04, 32'h0000_0000);
    repeat (SC + 8) @(posedge clk);
    chk({31'h0000_0000, lst}, 32'h0000_0000);
    wr_reg(8'h04, 32'h0000_0001);
    repeat (SC + 8) @(posedge clk);
    chk({31'h0000_0000, lst}, 32'h0000_0001);
    $display("monitor test done");
    wr_reg(8'h04, 32'h0000_0000);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, lst}, 32'h0000_0000);
    nrst <= 1'b1;
    rd_reg(8'h04, got);
    chk(got, 32'h0000_0001);
    rd_reg(8'h00, got);
    chk(got, 32'h0000_0000);
    $display("reset test done");
    summarize();
  end
endmodule
